// *** dsaa_pkg.sv ***
package dsaa_pkg;
  // address space layout
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int WIN_BIT = 15;
  localparam int LSB_BIT = 0;
  localparam logic [15:0] CTRL_REGION_LAST = 16'h0FFF;
  localparam logic [15:0] NEAR_REGION_LAST = 16'h1FFF;
  localparam logic [15:0] IMPL_LAST = 16'h2FFF;
  localparam int NEAR_FIELD_W = 13;
  localparam int MEM_WORDS = 4096;
  localparam int MEM_FIRST_WORD = 2048;
  localparam int MEM_IDX_W = 12;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONES_BYTE = 8'hFF;

  // addressing modes for the address generators
  typedef enum logic [1:0] {
    DSAA_MODE_NEAR,
    DSAA_MODE_DIRECT,
    DSAA_MODE_INDIRECT,
    DSAA_MODE_INDIRECT_POSTINC
  } dsaa_mode_t;

  // working-register byte operations
  typedef enum logic [1:0] {
    DSAA_WOP_NONE,
    DSAA_WOP_LOAD_BYTE,
    DSAA_WOP_WIDEN_SIGNED,
    DSAA_WOP_CLEAR_HIGH
  } dsaa_wop_t;

  // one request to an address generator
  typedef struct packed {
    logic valid;
    logic word_size;
    dsaa_mode_t mode;
    logic [15:0] field;
    logic [15:0] pointer;
  } dsaa_req_t;

  // result of a generated address
  typedef struct packed {
    logic [15:0] byte_pointer;
    logic [15:0] next_pointer;
    logic ptr_update;
  } dsaa_agu_t;
endpackage : dsaa_pkg

// *** dsaa_agu.sv ***
module dsaa_agu
  import dsaa_pkg::*;
(
  input wire dsaa_pkg::dsaa_req_t req,
  output dsaa_pkg::dsaa_agu_t res
);
  // byte pointer formation and pointer post-increment
  always_comb begin
    res = '0;
    case (req.mode)
      DSAA_MODE_NEAR: res.byte_pointer = {3'h0, req.field[NEAR_FIELD_W-1:0]};
      DSAA_MODE_DIRECT: res.byte_pointer = req.field;
      DSAA_MODE_INDIRECT: res.byte_pointer = req.pointer;
      DSAA_MODE_INDIRECT_POSTINC: begin
        res.byte_pointer = req.pointer;
        res.ptr_update = req.valid;
        res.next_pointer = req.pointer + (req.word_size ? STEP_WORD : STEP_BYTE);
      end
      default: res.byte_pointer = req.pointer;
    endcase
    if (req.mode != DSAA_MODE_INDIRECT_POSTINC) begin
      res.next_pointer = req.pointer;
    end
  end
endmodule : dsaa_agu

// *** dsaa_wreg_op.sv ***
module dsaa_wreg_op
  import dsaa_pkg::*;
(
  input wire dsaa_pkg::dsaa_wop_t op,
  input wire logic [15:0] reg_in,
  input wire logic [7:0] byte_in,
  output logic [15:0] reg_out
);
  // working-register byte merge and extension
  always_comb begin
    case (op)
      DSAA_WOP_LOAD_BYTE: reg_out = {reg_in[15:8], byte_in};
      DSAA_WOP_WIDEN_SIGNED: reg_out = {(reg_in[7] ? ONES_BYTE : ZERO_BYTE), reg_in[7:0]};
      DSAA_WOP_CLEAR_HIGH: reg_out = {ZERO_BYTE, reg_in[7:0]};
      default: reg_out = reg_in;
    endcase
  end
endmodule : dsaa_wreg_op

// *** dsaa_access.sv ***
// Overview of operation
// - byte pointers are 16 bits, 64 KB range
// - bit 15 clear is data, set is window
// - data space above implemented memory reads zero
// - low byte even address, high byte odd
// - post-increment by one byte, two word
// - byte read picks lane, delivers low lane
// - shared word decode, per-lane write strobes
// - odd word access raises address error trap
// - misaligned read still completes, one cycle after trap
// - misaligned write blocked, then trap taken
// - byte load changes only low byte
// - widen signed and clear high byte ops
// - first 4 KB is control register region
// - unused control addresses read zero, unless a same-cycle control write holds the port address
// - near region via 13-bit direct field
// - whole space by direct or pointer
// - separate read and write address generators
module dsaa_access
  import dsaa_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire dsaa_pkg::dsaa_req_t rd_req,
  input wire dsaa_pkg::dsaa_req_t wr_req,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic [15:0] rd_next_pointer,
  output logic rd_ptr_update,
  output logic [15:0] wr_next_pointer,
  output logic wr_ptr_update,
  output logic ctrl_sel,
  output logic [15:0] ctrl_addr,
  output logic [1:0] ctrl_wr_lane,
  output logic [15:0] ctrl_wr_data,
  input wire logic [15:0] ctrl_rd_data,
  input wire logic ctrl_rd_hit,
  output logic win_rd,
  output logic [15:0] win_addr,
  input wire logic [15:0] win_rd_data,
  input wire dsaa_pkg::dsaa_wop_t wop,
  input wire logic [15:0] wreg_in,
  output logic [15:0] wreg_out,
  output logic trap_req,
  output logic trap_on_write
);
  dsaa_agu_t rd_res;
  dsaa_agu_t wr_res;
  logic [15:0] wr_word;
  logic [15:0] ctrl_word_q;
  logic [7:0] lane_lo [MEM_WORDS];
  logic [7:0] lane_hi [MEM_WORDS];
  logic rd_misalign;
  logic wr_misalign;
  logic rd_in_mem;
  logic wr_in_mem;
  logic rd_in_ctrl;
  logic wr_in_ctrl;
  logic rd_in_win;
  logic [1:0] wr_lane;
  logic rd_pend_q;
  logic rd_word_q;
  logic rd_odd_q;
  logic [1:0] rd_src_q;
  logic [15:0] mem_word_q;
  logic ctrl_hit_q;
  logic [15:0] raw_word;
  logic [7:0] rd_byte;

  // independent read and write address generators
  dsaa_agu u_rd_agu (.req(rd_req), .res(rd_res));
  dsaa_agu u_wr_agu (.req(wr_req), .res(wr_res));

  // working-register byte handling
  dsaa_wreg_op u_wreg (.op(wop), .reg_in(wreg_in), .byte_in(rd_data[7:0]), .reg_out(wreg_out));

  // odd byte pointer on a word access
  function automatic logic misaligned(input dsaa_req_t r, input logic [15:0] bp);
    misaligned = r.valid && r.word_size && bp[LSB_BIT];
  endfunction : misaligned

  // implemented data memory above the control region
  function automatic logic in_mem(input logic [15:0] bp);
    in_mem = !bp[WIN_BIT] && (bp > CTRL_REGION_LAST) && (bp <= IMPL_LAST);
  endfunction : in_mem

  // control register region decode
  function automatic logic in_ctrl(input logic [15:0] bp);
    in_ctrl = !bp[WIN_BIT] && (bp <= CTRL_REGION_LAST);
  endfunction : in_ctrl

  // word index into the array from the shared word decode
  function automatic logic [11:0] word_idx(input logic [15:0] bp);
    logic [14:0] w;
    w = bp[15:1] - 15'(MEM_FIRST_WORD);
    word_idx = w[MEM_IDX_W-1:0];
  endfunction : word_idx

  // address classification
  always_comb begin
    rd_misalign = misaligned(rd_req, rd_res.byte_pointer);
    wr_misalign = misaligned(wr_req, wr_res.byte_pointer);
    rd_in_mem = in_mem(rd_res.byte_pointer);
    wr_in_mem = in_mem(wr_res.byte_pointer);
    rd_in_ctrl = in_ctrl(rd_res.byte_pointer);
    wr_in_ctrl = in_ctrl(wr_res.byte_pointer);
    rd_in_win = rd_res.byte_pointer[WIN_BIT];
  end

  // per-lane write strobes, blocked on misalignment
  always_comb begin
    wr_lane = 2'b00;
    if (wr_req.valid && !wr_misalign && clk_en) begin
      if (wr_req.word_size) begin
        wr_lane = 2'b11;
      end else begin
        wr_lane = wr_res.byte_pointer[LSB_BIT] ? 2'b10 : 2'b01;
      end
    end
  end

  // byte write data goes on the lane of its address
  function automatic logic [15:0] lane_data(input logic word, input logic [15:0] d);
    lane_data = word ? d : {d[7:0], d[7:0]};
  endfunction : lane_data

  // write word steered onto its lanes, shared by memory and control port
  always_comb begin
    wr_word = lane_data(wr_req.word_size, wr_data);
  end

  // data memory array, two byte-wide halves
  always_ff @(posedge clk) begin
    if (clk_en && wr_in_mem && !srst) begin
      if (wr_lane[0]) begin
        lane_lo[word_idx(wr_res.byte_pointer)] <= wr_word[7:0];
      end
      if (wr_lane[1]) begin
        lane_hi[word_idx(wr_res.byte_pointer)] <= wr_word[15:8];
      end
    end
  end

  // control-region write port
  always_comb begin
    ctrl_sel = (rd_req.valid && rd_in_ctrl) || (wr_req.valid && wr_in_ctrl);
    ctrl_addr = (wr_req.valid && wr_in_ctrl) ? wr_res.byte_pointer : rd_res.byte_pointer;
    ctrl_wr_lane = wr_in_ctrl ? wr_lane : 2'b00;
    ctrl_wr_data = wr_word;
  end

  // program-space window forwarding
  always_comb begin
    win_rd = rd_req.valid && rd_in_win && clk_en;
    win_addr = rd_res.byte_pointer;
  end

  // pointer post-increment outputs, read update kept and write update dropped on misalignment
  always_comb begin
    rd_next_pointer = rd_res.next_pointer;
    rd_ptr_update = rd_res.ptr_update && clk_en;
    wr_next_pointer = wr_res.next_pointer;
    wr_ptr_update = wr_res.ptr_update && clk_en && !wr_misalign;
  end

  // read stage: fetch whole word, remember how to pick
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_pend_q <= 1'b0;
      rd_word_q <= 1'b0;
      rd_odd_q <= 1'b0;
      rd_src_q <= 2'd0;
    end else if (clk_en) begin
      rd_pend_q <= rd_req.valid;
      rd_word_q <= rd_req.word_size;
      rd_odd_q <= rd_res.byte_pointer[LSB_BIT];
      rd_src_q <= rd_in_win ? 2'd3 : rd_in_mem ? 2'd1 : rd_in_ctrl ? 2'd2 : 2'd0;
    end
  end

  // whole word fetch from the array
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_word_q <= ZERO_WORD;
      ctrl_hit_q <= 1'b0;
      ctrl_word_q <= ZERO_WORD;
    end else if (clk_en) begin
      mem_word_q <= {lane_hi[word_idx(rd_res.byte_pointer)], lane_lo[word_idx(rd_res.byte_pointer)]};
      ctrl_hit_q <= ctrl_rd_hit;
      ctrl_word_q <= ctrl_rd_data; // port answers only while the request stands
    end
  end

  // source select, zero for unimplemented locations
  always_comb begin
    case (rd_src_q)
      2'd1: raw_word = mem_word_q;
      2'd2: raw_word = ctrl_hit_q ? ctrl_word_q : ZERO_WORD;
      2'd3: raw_word = win_rd_data;
      default: raw_word = ZERO_WORD;
    endcase
    rd_byte = rd_odd_q ? raw_word[15:8] : raw_word[7:0];
  end

  // read data register, byte on the low lane
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= ZERO_WORD;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= rd_pend_q;
      if (rd_pend_q) begin
        rd_data <= rd_word_q ? raw_word : {ZERO_BYTE, rd_byte};
      end
    end
  end

  // trap request pulse with direction flag
  always_ff @(posedge clk) begin
    if (srst) begin
      trap_req <= 1'b0;
      trap_on_write <= 1'b0;
    end else if (clk_en) begin
      trap_req <= rd_misalign || wr_misalign;
      if (rd_misalign || wr_misalign) begin
        trap_on_write <= wr_misalign;
      end
    end else begin
      trap_req <= 1'b0;
    end
  end

  sequence s_word_odd_write;
    wr_req.valid && wr_req.word_size && wr_res.byte_pointer[0] && clk_en;
  endsequence

  sequence s_trap_write;
    trap_req && trap_on_write;
  endsequence

  a_trap_on_odd: assert property (@(posedge clk) disable iff (srst)
    (clk_en && (rd_misalign || wr_misalign)) |=> trap_req)
    else $error("misaligned word access did not raise trap");

  a_trap_is_pulse: assert property (@(posedge clk) disable iff (srst)
    trap_req |-> !$past(trap_req) || $past(rd_misalign || wr_misalign))
    else $error("trap request held without a new fault");

  a_write_flag: assert property (@(posedge clk) disable iff (srst)
    s_word_odd_write |=> s_trap_write)
    else $error("write fault not flagged as write");

  a_write_blocked: assert property (@(posedge clk) disable iff (srst)
    s_word_odd_write |-> (wr_lane == 2'b00) && (ctrl_wr_lane == 2'b00))
    else $error("misaligned write reached a byte lane");

  a_byte_one_lane: assert property (@(posedge clk) disable iff (srst)
    (wr_req.valid && !wr_req.word_size && clk_en) |-> $onehot(wr_lane) && (wr_lane[1] == wr_res.byte_pointer[0]))
    else $error("byte write strobed the wrong lane");

  a_read_done: assert property (@(posedge clk) disable iff (srst)
    (clk_en && rd_req.valid && rd_misalign) ##1 clk_en |=> rd_valid)
    else $error("misaligned read did not complete");

  a_unimpl_zero: assert property (@(posedge clk) disable iff (srst)
    (clk_en && rd_req.valid && !rd_in_mem && !rd_in_ctrl && !rd_in_win) ##1 clk_en |=> rd_data == ZERO_WORD)
    else $error("unimplemented location read nonzero");

  a_byte_low_lane: assert property (@(posedge clk) disable iff (srst)
    (clk_en && rd_req.valid && !rd_req.word_size) ##1 clk_en |=> rd_data[15:8] == ZERO_BYTE)
    else $error("byte read used the high lane");

  a_postinc_step: assert property (@(posedge clk) disable iff (srst)
    rd_ptr_update |-> rd_next_pointer == rd_req.pointer + (rd_req.word_size ? STEP_WORD : STEP_BYTE))
    else $error("pointer step wrong for access size");

  a_window_route: assert property (@(posedge clk) disable iff (srst)
    (clk_en && rd_req.valid && rd_res.byte_pointer[15]) |-> win_rd && !(ctrl_sel && ctrl_addr == rd_res.byte_pointer))
    else $error("upper half not sent to window");

  // a word read taken in the window, then an enabled fetch edge
  sequence s_win_word_read;
    (clk_en && rd_req.valid && rd_in_win && rd_req.word_size) ##1 clk_en;
  endsequence

  // an unmatched read in the control region, then an enabled fetch edge
  sequence s_ctrl_miss_read;
    (clk_en && rd_req.valid && rd_in_ctrl && !ctrl_rd_hit) ##1 clk_en;
  endsequence

  a_window_data: assert property (@(posedge clk) disable iff (srst)
    s_win_word_read |=> rd_data == $past(win_rd_data))
    else $error("window word not returned as answered");

  a_ctrl_miss_zero: assert property (@(posedge clk) disable iff (srst)
    s_ctrl_miss_read |=> rd_data == ZERO_WORD)
    else $error("unused control address read nonzero");

  a_trap_read_flag: assert property (@(posedge clk) disable iff (srst)
    (clk_en && rd_misalign && !wr_misalign) |=> trap_req && !trap_on_write)
    else $error("read fault not flagged as read");

  a_ctrl_lanes: assert property (@(posedge clk) disable iff (srst)
    (clk_en && wr_req.valid && wr_in_ctrl && !wr_misalign) |-> ctrl_sel && (ctrl_addr == wr_res.byte_pointer) && (ctrl_wr_lane == wr_lane))
    else $error("control write not strobed at its address");

  a_no_stray_lane: assert property (@(posedge clk) disable iff (srst)
    (ctrl_wr_lane != 2'h0) |-> wr_req.valid && wr_in_ctrl)
    else $error("control strobe without a control write");

  a_word_two_lanes: assert property (@(posedge clk) disable iff (srst)
    (clk_en && wr_req.valid && wr_req.word_size && !wr_misalign) |-> wr_lane == 2'h3)
    else $error("aligned word write missed a lane");

  a_near_bound: assert property (@(posedge clk) disable iff (srst)
    (rd_req.valid && rd_req.mode == DSAA_MODE_NEAR) |-> rd_res.byte_pointer <= NEAR_REGION_LAST)
    else $error("near address left the near region");

  a_odd_byte_data: assert property (@(posedge clk) disable iff (srst)
    (ctrl_wr_lane == 2'h2) |-> ctrl_wr_data[15:8] == wr_data[7:0])
    else $error("odd byte write data not on high lane");

  a_wr_ptr_held: assert property (@(posedge clk) disable iff (srst)
    (clk_en && wr_misalign) |-> !wr_ptr_update)
    else $error("faulting write advanced its pointer");

  a_wr_postinc: assert property (@(posedge clk) disable iff (srst)
    wr_ptr_update |-> wr_next_pointer == wr_req.pointer + (wr_req.word_size ? STEP_WORD : STEP_BYTE))
    else $error("write pointer step wrong for access size");

  a_enable_freeze: assert property (@(posedge clk) disable iff (srst)
    !clk_en |-> (wr_lane == 2'h0) && !win_rd && !rd_ptr_update && !wr_ptr_update)
    else $error("activity while the clock enable is low");

  a_window_addr: assert property (@(posedge clk) disable iff (srst)
    win_rd |-> (win_addr == rd_res.byte_pointer) && win_addr[WIN_BIT])
    else $error("window address not the read pointer");
endmodule : dsaa_access

// *** dsaa_far_model.sv ***
module dsaa_far_model
  import dsaa_pkg::*;
(
  input wire logic clk,
  input wire logic ctrl_sel,
  input wire logic [15:0] ctrl_addr,
  input wire logic [1:0] ctrl_wr_lane,
  input wire logic [15:0] ctrl_wr_data,
  output logic [15:0] ctrl_rd_data,
  output logic ctrl_rd_hit,
  input wire logic win_rd,
  input wire logic [15:0] win_addr,
  output logic [15:0] win_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] regs_q [16];
  logic [15:0] idle_q = 16'h0000;
  logic [15:0] win_q = 16'h0000;
  // only the first 32 bytes hold registers, the rest is unused
  assign ctrl_rd_hit = ctrl_sel && (ctrl_addr < 16'h0020);
  assign ctrl_rd_data = ctrl_rd_hit ? regs_q[ctrl_addr[4:1]] : ~idle_q;
  assign win_rd_data = win_q;
  // lane writes, idle pattern churns every cycle
  always @(posedge clk) begin
    idle_q <= idle_q + 16'h0001;
    if (ctrl_rd_hit && ctrl_wr_lane[0]) regs_q[ctrl_addr[4:1]][7:0] <= ctrl_wr_data[7:0];
    if (ctrl_rd_hit && ctrl_wr_lane[1]) regs_q[ctrl_addr[4:1]][15:8] <= ctrl_wr_data[15:8];
  end
  // window answers one cycle after the request, else churns
  always @(posedge clk) begin
    win_q <= win_rd ? {win_addr[7:0], win_addr[15:8]} : ~win_q;
  end
endmodule : dsaa_far_model

// *** tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dsaa_pkg::*;
  logic clk = 0, srst = 1, clk_en = 1;
  dsaa_req_t rd_req = '0, wr_req = '0;
  dsaa_wop_t wop = DSAA_WOP_NONE;
  logic [15:0] wr_data = '0, wreg_in = '0, rd_data, rd_np, wr_np, ctrl_addr, ctrl_wr_data;
  logic [15:0] ctrl_rd_data, win_addr, win_rd_data, wreg_out, got, np_s;
  logic [1:0] ctrl_wr_lane;
  logic rd_valid, rd_pu, wr_pu, ctrl_sel, ctrl_rd_hit, win_rd, trap_req, trap_on_write, pu_s, trap_w;
  int fails = 0, checks_done = 0, trap_n = 0;
  dsaa_access DUT (.clk(clk), .srst(srst), .clk_en(clk_en), .rd_req(rd_req), .wr_req(wr_req),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .rd_next_pointer(rd_np),
    .rd_ptr_update(rd_pu), .wr_next_pointer(wr_np), .wr_ptr_update(wr_pu), .ctrl_sel(ctrl_sel),
    .ctrl_addr(ctrl_addr), .ctrl_wr_lane(ctrl_wr_lane), .ctrl_wr_data(ctrl_wr_data),
    .ctrl_rd_data(ctrl_rd_data), .ctrl_rd_hit(ctrl_rd_hit), .win_rd(win_rd), .win_addr(win_addr),
    .win_rd_data(win_rd_data), .wop(wop), .wreg_in(wreg_in), .wreg_out(wreg_out),
    .trap_req(trap_req), .trap_on_write(trap_on_write));
  dsaa_far_model far (.clk(clk), .ctrl_sel(ctrl_sel), .ctrl_addr(ctrl_addr), .ctrl_wr_lane(ctrl_wr_lane),
    .ctrl_wr_data(ctrl_wr_data), .ctrl_rd_data(ctrl_rd_data), .ctrl_rd_hit(ctrl_rd_hit),
    .win_rd(win_rd), .win_addr(win_addr), .win_rd_data(win_rd_data));
  // clock
  initial begin
    forever #2 clk = ~clk;
  end
  // count trap pulses, sampled mid-cycle
  always @(negedge clk) begin
    if (trap_req === 1'b1) begin
      trap_n++;
      trap_w = trap_on_write;
    end
  end
  task automatic report_and_stop;
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic dsaa_req_t mk(input logic w, input dsaa_mode_t m, input logic [15:0] a);
    mk = '{1'b1, w, m, a, a};
  endfunction : mk
  task automatic wr(input logic w, input dsaa_mode_t m, input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    wr_req = mk(w, m, a);
    wr_data = d;
    #1 pu_s = wr_pu;
    np_s = wr_np;
    @(negedge clk);
    wr_req.valid = 1'b0;
  endtask : wr
  task automatic wait_rd;
    int i;
    @(negedge clk);
    rd_req.valid = 1'b0;
    wr_req.valid = 1'b0;
    for (i = 0; i < 6 && rd_valid !== 1'b1; i++) @(negedge clk);
    if (i == 6) begin
      fails++;
      report_and_stop();
    end
    got = rd_data;
  endtask : wait_rd
  task automatic rd(input logic w, input dsaa_mode_t m, input logic [15:0] a);
    @(negedge clk);
    rd_req = mk(w, m, a);
    #1 pu_s = rd_pu;
    np_s = rd_np;
    wait_rd();
  endtask : rd
  // words across the implemented range, then lanes
  task automatic t_mem;
    logic [15:0] ad [4] = '{16'h1000, 16'h1FFE, 16'h2000, 16'h2FFE};
    foreach (ad[i]) wr(1'b1, DSAA_MODE_DIRECT, ad[i], ad[i] ^ 16'h5A3C);
    foreach (ad[i]) begin
      rd(1'b1, DSAA_MODE_INDIRECT, ad[i]);
      chk("word", got, ad[i] ^ 16'h5A3C);
    end
    chk("no update", {15'h0000, pu_s}, 16'h0000);
    wr(1'b0, DSAA_MODE_INDIRECT, 16'h1001, 16'hA2B7);
    wr(1'b0, DSAA_MODE_INDIRECT, 16'h1000, 16'h55C4);
    rd(1'b1, DSAA_MODE_DIRECT, 16'h1000);
    chk("lanes", got, 16'hB7C4);
    rd(1'b0, DSAA_MODE_DIRECT, 16'h1000);
    chk("byte even", got, 16'h00C4);
    rd(1'b0, DSAA_MODE_DIRECT, 16'h1001);
    chk("byte odd", got, 16'h00B7);
    @(negedge clk);
    wreg_in = 16'hA1B2;
    wop = DSAA_WOP_LOAD_BYTE;
    #1 chk("load byte", wreg_out, 16'hA1B7);
    wreg_in = 16'h3485;
    wop = DSAA_WOP_WIDEN_SIGNED;
    #1 chk("widen", wreg_out, 16'hFF85);
    wop = DSAA_WOP_CLEAR_HIGH;
    #1 chk("clear high", wreg_out, 16'h0085);
    wop = DSAA_WOP_NONE;
  endtask : t_mem
  // odd word write blocked, odd word read completes, both trap
  task automatic t_trap;
    wr(1'b1, DSAA_MODE_DIRECT, 16'h1020, 16'h1234);
    trap_n = 0;
    wr(1'b1, DSAA_MODE_INDIRECT_POSTINC, 16'h1021, 16'hFFFF);
    chk("blocked update", {15'h0000, pu_s}, 16'h0000);
    repeat (3) @(negedge clk);
    chk("write traps", trap_n[15:0], 16'h0001);
    chk("write flag", {15'h0000, trap_w}, 16'h0001);
    rd(1'b1, DSAA_MODE_DIRECT, 16'h1020);
    chk("write blocked", got, 16'h1234);
    trap_n = 0;
    rd(1'b1, DSAA_MODE_DIRECT, 16'h1021);
    repeat (2) @(negedge clk);
    chk("read traps", trap_n[15:0], 16'h0001);
    chk("read flag", {15'h0000, trap_w}, 16'h0000);
  endtask : t_trap
  // zero fill, control region, window
  task automatic t_regions;
    rd(1'b1, DSAA_MODE_DIRECT, 16'h3000);
    chk("above memory", got, 16'h0000);
    rd(1'b0, DSAA_MODE_DIRECT, 16'h7FFF);
    chk("above memory byte", got, 16'h0000);
    wr(1'b1, DSAA_MODE_NEAR, 16'h0010, 16'h9C3D);
    wr(1'b0, DSAA_MODE_NEAR, 16'h0011, 16'h0077);
    rd(1'b1, DSAA_MODE_NEAR, 16'h0010);
    chk("control reg", got, 16'h773D);
    rd(1'b1, DSAA_MODE_DIRECT, 16'h0400);
    chk("control unused", got, 16'h0000);
    wr(1'b1, DSAA_MODE_NEAR, 16'h1FFC, 16'h6E21);
    rd(1'b1, DSAA_MODE_INDIRECT, 16'h1FFC);
    chk("near top", got, 16'h6E21);
    rd(1'b1, DSAA_MODE_DIRECT, 16'h8642);
    chk("window", got, 16'h4286);
  endtask : t_regions
  // post-increment steps and a read beside a write
  task automatic t_ptr;
    rd(1'b0, DSAA_MODE_INDIRECT_POSTINC, 16'h1040);
    chk("rd step byte", pu_s ? np_s : 16'hFFFF, 16'h1041);
    rd(1'b1, DSAA_MODE_INDIRECT_POSTINC, 16'h1042);
    chk("rd step word", pu_s ? np_s : 16'hFFFF, 16'h1044);
    wr(1'b0, DSAA_MODE_INDIRECT_POSTINC, 16'h1051, 16'h0001);
    chk("wr step byte", pu_s ? np_s : 16'hFFFF, 16'h1052);
    wr(1'b1, DSAA_MODE_INDIRECT_POSTINC, 16'h1052, 16'h0002);
    chk("wr step word", pu_s ? np_s : 16'hFFFF, 16'h1054);
    wr(1'b1, DSAA_MODE_DIRECT, 16'h1060, 16'h0102);
    @(negedge clk);
    rd_req = mk(1'b1, DSAA_MODE_DIRECT, 16'h1060);
    wr_req = mk(1'b1, DSAA_MODE_DIRECT, 16'h1062);
    wr_data = 16'h0304;
    wait_rd();
    chk("dual read", got, 16'h0102);
    rd(1'b1, DSAA_MODE_DIRECT, 16'h1062);
    chk("dual write", got, 16'h0304);
    wr(1'b1, DSAA_MODE_DIRECT, 16'h1070, 16'h1111);
    @(negedge clk);
    clk_en = 1'b0;
    wr(1'b1, DSAA_MODE_INDIRECT_POSTINC, 16'h1070, 16'h2222);
    chk("frozen pointer", {15'h0000, pu_s}, 16'h0000);
    clk_en = 1'b1;
    rd(1'b1, DSAA_MODE_DIRECT, 16'h1070);
    chk("frozen write", got, 16'h1111);
  endtask : t_ptr
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    t_mem();
    t_trap();
    t_regions();
    t_ptr();
    report_and_stop();
  end
endmodule : tb_top
